// ---- hw/drs_pkg.sv ----
// Package for the drive reference select block: register map, field layouts, timing constants
package drs_pkg;

    // APB register byte offsets
    localparam logic [7:0] REG_CTRL        = 8'h00;  // Control source, actual index, gate/func codes
    localparam logic [7:0] REG_STATUS      = 8'h04;  // Job state and chosen index
    localparam logic [7:0] REG_FIELDBUS    = 8'h08;  // Fieldbus control word
    localparam logic [7:0] REG_ANA_FUNC    = 8'h0c;  // Function selector for both channels
    localparam logic [7:0] REG_FILT        = 8'h10;  // Filter time per channel in ms
    localparam logic [7:0] REG_POS_REF     = 8'h14;  // Held position target of channel 0, read only
    localparam logic [7:0] REG_CH_BASE     = 8'h40;  // Per channel block base
    localparam logic [7:0] REG_CH_STRIDE   = 8'h40;  // Channel 1 block at base plus stride
    // Word offsets inside a channel block
    localparam logic [3:0] CH_SCALE0       = 4'h0;   // Scale index 0..2 at words 0..2
    localparam logic [3:0] CH_OFFS0        = 4'h3;   // Offsets at words 3..5
    localparam logic [3:0] CH_BAND0        = 4'h6;   // Bands at words 6..8
    localparam logic [3:0] CH_SRAMP0       = 4'h9;   // Speed ramps at words 9..10
    localparam logic [3:0] CH_TRAMP0       = 4'hb;   // Torque ramps at words 11..12
    localparam logic [3:0] CH_SAMPLE       = 4'hd;   // Analog sample, read only
    localparam logic [3:0] CH_PSPD         = 4'he;   // Position speed limit
    localparam logic [3:0] CH_NWORDS       = 4'hf;   // Words per channel

    // Control register field positions
    localparam int CTRL_SRC_LSB   = 0;   // Two bits: table control source
    localparam int CTRL_IDX_LSB   = 4;   // Four bits: actual set index
    localparam int CTRL_LOAD_BIT  = 8;   // Write one: start parameter job
    localparam int CTRL_MODE_LSB  = 12;  // Two bits: positioning mode
    localparam int CTRL_GSEL_LSB  = 16;  // Three bits: which digital input gates position reference
    localparam int CTRL_GFUN_LSB  = 24;  // Six bits: function code of that input
    localparam int FB_EXEC_BIT    = 4;   // Fieldbus execute bit above four index bits

    localparam logic [5:0] FUNC_GATE_CODE = 6'h1c;   // Function code 28
    localparam logic signed [7:0] FUNC_ANALOG_CMD = -8'sd2;  // Analog command, +/-10 V
    localparam logic [31:0] CTRL_RESET    = 32'h1c00_0001;  // Terminal source, gate code 28 on input 0

    // Clock and time
    localparam int CLK_HZ      = 125_000_000;
    localparam int MS_PER_S    = 1000;
    localparam int CYC_PER_MS  = CLK_HZ / MS_PER_S;   // One filter step per millisecond
    localparam int FILT_MAX_MS = 100;

    typedef enum logic [1:0] {
        SRC_PARA = 2'b00,
        SRC_TERM = 2'b01,
        SRC_AUTO = 2'b10,
        SRC_BUS  = 2'b11
    } drs_src_e;

    typedef enum logic [1:0] {
        PM_ABS    = 2'b00,
        PM_REL    = 2'b01,
        PM_REL_AT = 2'b10,
        PM_SPEED  = 2'b11
    } drs_pmode_e;

    typedef enum logic [1:0] {
        JOB_IDLE  = 2'b00,
        JOB_START = 2'b01,
        JOB_RUN   = 2'b10
    } drs_job_e;

    // Job request handed to the motion profile
    typedef struct packed {
        logic       start;      // One-cycle start pulse
        logic       abort;      // One-cycle abort of running positioning
        logic       seq_abort;  // One-cycle abort of follow-up sequencing
        logic [3:0] index;      // Chosen driving set
        logic       from_pos;   // Start from present position
    } drs_job_s;

    // Per channel analog parameters
    typedef struct packed {
        logic signed [15:0] scale;
        logic signed [31:0] offset;
        logic        [31:0] band;
        logic        [31:0] step;
    } drs_anapar_s;

endpackage

// ---- hw/drs_ana_chan.sv ----
// One analog channel: filter, scaling, offset, run-on band, ramp and gate
`timescale 1ns/1ps
module drs_ana_chan
    import drs_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               ms_tick,     // One pulse per millisecond
    input  wire logic               tick,        // Ramp step enable
    input  wire logic               enable,      // Channel is an analog command input
    input  wire logic               gate,        // Position reference gate, synchronised
    input  wire logic [6:0]         filt_ms,     // Filter time in ms
    input  wire logic signed [15:0] sample,      // Raw sample, full scale = +/-10 V
    input  wire drs_anapar_s        par,         // Scale, offset, band, step
    output logic signed [31:0]      ref_out,     // Ramped applied reference
    output logic signed [31:0]      target_out   // Held target after band
);
    ////////////////////////////////////////////////////////////////////////
    logic signed [15:0] filt_r, filt_nxt;      // First order filter state
    logic signed [31:0] tgt_r, tgt_nxt;        // Band-held target
    logic signed [31:0] ref_r, ref_nxt;        // Ramp output
    logic signed [31:0] raw;                   // Scaled plus offset
    logic signed [31:0] diff;                  // Distance to held target
    logic signed [31:0] err;                   // Ramp error
    logic        [31:0] mag;                   // Absolute band distance
    logic signed [16:0] fd;                    // Filter difference

    // Filter, scaling, band and ramp next values
    always_comb begin
        fd       = 17'(sample) - 17'(filt_r);
        filt_nxt = filt_r;
        if (filt_ms == 7'h00) begin             // Zero time: pass through
            filt_nxt = sample;
        end else if (ms_tick) begin
            filt_nxt = 16'(filt_r + 16'(fd / $signed({10'h000, filt_ms})));
        end
        // Full bipolar range maps to scale, then offset added
        raw  = 32'((32'(filt_r) * 32'(par.scale)) >>> 15) + par.offset;
        diff = raw - tgt_r;
        mag  = diff[31] ? 32'(-diff) : 32'(diff);
        tgt_nxt = tgt_r;
        // Gate false keeps last target; inside band the target holds while the ramp output still moves toward it
        if (enable && gate && (mag > par.band)) begin
            tgt_nxt = raw;
        end
        err     = tgt_r - ref_r;
        ref_nxt = ref_r;
        if (tick) begin
            if (err > $signed(par.step)) begin
                ref_nxt = ref_r + $signed(par.step);
            end else if (-err > $signed(par.step)) begin
                ref_nxt = ref_r - $signed(par.step);
            end else begin
                ref_nxt = tgt_r;
            end
        end
    end

    // State registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            filt_r <= 16'h0000;
            tgt_r  <= 32'h0000_0000;
            ref_r  <= 32'h0000_0000;
        end else begin
            filt_r <= filt_nxt;
            tgt_r  <= tgt_nxt;
            ref_r  <= ref_nxt;
        end
    end

    assign ref_out    = ref_r;
    assign target_out = tgt_r;
endmodule // drs_ana_chan

// ---- hw/drs_top.sv ----
// Drive reference select: driving set selection and analog reference processing
//
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
module drs_top
    import drs_pkg::*;
(
    input  wire logic               CLOCK,
    input  wire logic               RST,
    input  wire logic [31:0]        PADDR,
    input  wire logic               PSEL,
    input  wire logic               PENABLE,
    input  wire logic               PWRITE,
    input  wire logic [31:0]        PWDATA,
    output logic                    PREADY,
    output logic [31:0]             PRDATA,
    output logic                    PSLVERR,
    input  wire logic [3:0]         SET_SELECT_BITS,
    input  wire logic               TABLE_JOB_ENABLE,
    input  wire logic [6:0]         DIGITAL_IN,
    input  wire logic signed [15:0] ANALOG_IN_FIRST,
    input  wire logic signed [15:0] ANALOG_IN_SECOND,
    output drs_job_s                JOB,
    output logic [3:0]              ACTUAL_SET_INDEX,
    output logic signed [31:0]      POS_REF_FIRST,
    output logic signed [31:0]      POS_REF_SECOND,
    output logic signed [31:0]      SPEED_REF_FIRST,
    output logic signed [31:0]      SPEED_REF_SECOND
);
    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: two flops before any logic
    logic [11:0] sy1_r, sy2_r;          // Select, enable, digital inputs
    logic [11:0] pins;                  // Raw pin group
    logic        en_d_r;                // Enable delayed for edge detect
    logic [3:0]  sel_s;                 // Synchronised select inputs
    logic        en_s;                  // Synchronised enable
    logic [6:0]  din_s;                 // Synchronised digital inputs

    assign pins  = {DIGITAL_IN, TABLE_JOB_ENABLE, SET_SELECT_BITS};
    assign sel_s = sy2_r[3:0];
    assign en_s  = sy2_r[4];
    assign din_s = sy2_r[11:5];

    // Two-stage synchroniser and edge delay
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            sy1_r  <= 12'h000;
            sy2_r  <= 12'h000;
            en_d_r <= 1'b0;
        end else begin
            sy1_r  <= pins;
            sy2_r  <= sy1_r;
            en_d_r <= en_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [31:0] ctrl_r, ctrl_nxt;                 // Control word
    logic [31:0] fb_r, fb_nxt;                     // Fieldbus control word
    logic [15:0] func_r, func_nxt;                 // Two signed function codes
    logic [13:0] filt_r, filt_nxt;                 // Two filter times
    logic [31:0] chw_r [2][CH_NWORDS];             // Channel parameter words
    logic [31:0] chw_nxt [2][CH_NWORDS];
    logic        load_r, load_nxt;                 // Parameter job request
    logic        fb_exec_d_r, fb_exec_d_nxt;       // Fieldbus execute history
    logic        wr_en;                            // Write taken this edge
    logic [7:0]  a8;                               // Low address byte
    logic        ch_hit;                           // Address in a channel block
    logic        ch_sel;                           // Which channel
    logic [3:0]  ch_word;                          // Word inside block
    logic [31:0] rdata;                            // Read mux
    logic        bad;                              // Unmapped address

    assign wr_en   = PSEL && PENABLE && PWRITE;
    assign a8      = PADDR[7:0];
    assign ch_hit  = (a8 >= REG_CH_BASE) && (a8 < REG_CH_BASE + 2 * REG_CH_STRIDE)
                     && (PADDR[31:8] == 24'h000000) && (PADDR[1:0] == 2'b00);
    assign ch_sel  = (a8 >= REG_CH_BASE + REG_CH_STRIDE);
    assign ch_word = a8[5:2];
    assign PREADY  = 1'b1;              // Zero wait states

    ////////////////////////////////////////////////////////////////////////
    // Job selection
    drs_job_e    st_r, st_nxt;                     // Job state
    logic [3:0]  idx_r, idx_nxt;                   // Chosen set index
    drs_job_s    job_r, job_nxt;                   // Job output pulses
    logic        trig;                             // New job request
    logic [3:0]  trig_idx;                         // Index for that request
    drs_src_e    src;                              // Control source
    logic        fb_exec;                          // Fieldbus execute bit

    assign src     = drs_src_e'(ctrl_r[CTRL_SRC_LSB +: 2]);
    assign fb_exec = fb_r[FB_EXEC_BIT];

    // Request selection and job pulses
    always_comb begin
        trig     = 1'b0;
        trig_idx = idx_r;
        case (src)
            SRC_PARA: begin
                trig     = load_r;
                trig_idx = ctrl_r[CTRL_IDX_LSB +: 4];
            end
            SRC_TERM, SRC_AUTO: begin
                trig     = en_s && !en_d_r;
                trig_idx = sel_s;
            end
            SRC_BUS: begin
                trig     = fb_exec && !fb_exec_d_r;
                trig_idx = fb_r[3:0];
            end
            default: begin
                trig = 1'b0;
            end
        endcase
        case (st_r)
            JOB_IDLE:  st_nxt = trig ? JOB_START : JOB_IDLE;
            JOB_START: st_nxt = JOB_RUN;
            JOB_RUN:   st_nxt = trig ? JOB_START : JOB_RUN;
            default:   st_nxt = JOB_IDLE;
        endcase
        idx_nxt           = trig ? trig_idx : idx_r;
        job_nxt.start     = trig;
        job_nxt.abort     = trig;
        job_nxt.seq_abort = trig;
        job_nxt.index     = trig_idx;
        job_nxt.from_pos  = trig && (ctrl_r[CTRL_MODE_LSB +: 2] == PM_REL_AT);
    end

    // Job state registers
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            st_r  <= JOB_IDLE;
            idx_r <= 4'h0;
            job_r <= '0;
        end else begin
            st_r  <= st_nxt;
            idx_r <= idx_nxt;
            job_r <= job_nxt;
        end
    end

    assign JOB              = job_r;
    assign ACTUAL_SET_INDEX = idx_r;

    ////////////////////////////////////////////////////////////////////////
    // Millisecond divider and gate input
    logic [16:0] div_r, div_nxt;                   // Cycle counter
    logic        ms_tick;                          // One pulse per ms
    logic        gate;                             // Gate input true
    logic [2:0]  gsel;                             // Gating input number

    assign gsel    = ctrl_r[CTRL_GSEL_LSB +: 3];
    assign ms_tick = (div_r == 17'(CYC_PER_MS - 1));
    // Only one of the first seven inputs, configured with code 28, gates
    assign gate    = (gsel < 3'd7) && (ctrl_r[CTRL_GFUN_LSB +: 6] == FUNC_GATE_CODE)
                     && din_s[gsel];

    always_comb begin
        div_nxt = ms_tick ? 17'h00000 : div_r + 17'h00001;
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            div_r <= 17'h00000;
        end else begin
            div_r <= div_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Two analog channels
    logic signed [31:0] pos_ref [2];
    logic signed [31:0] pos_tgt [2];
    logic signed [31:0] spd_ref [2];
    logic signed [15:0] ana [2];

    assign ana[0] = ANALOG_IN_FIRST;
    assign ana[1] = ANALOG_IN_SECOND;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_ch
            drs_anapar_s ppar;             // Position path parameters
            logic        en;               // Channel is analog command
            logic signed [31:0] sraw;      // Speed reference before ramp
            logic signed [31:0] sr_r, sr_nxt;
            logic signed [31:0] serr;
            // Code minus two selects analog command; every other code disables the channel
            assign en = ($signed(func_r[8*g +: 8]) == FUNC_ANALOG_CMD);
            assign ppar.scale  = chw_r[g][CH_SCALE0 + 4'd2][15:0];
            assign ppar.offset = chw_r[g][CH_OFFS0 + 4'd2];
            assign ppar.band   = chw_r[g][CH_BAND0 + 4'd2];
            assign ppar.step   = chw_r[g][CH_PSPD];
            drs_ana_chan u_chan (
                .clk        (CLOCK),
                .rst        (RST),
                .ms_tick    (ms_tick),
                .tick       (ms_tick),
                .enable     (en),
                .gate       (gate),
                .filt_ms    (filt_r[7*g +: 7]),
                .sample     (ana[g]),
                .par        (ppar),
                .ref_out    (pos_ref[g]),
                .target_out (pos_tgt[g])
            );
            // Speed path: index 1 scale/offset, separate accel and brake ramps
            assign sraw = en ? 32'((32'(ana[g]) * 32'($signed(chw_r[g][CH_SCALE0 + 4'd1][15:0]))) >>> 15)
                             + $signed(chw_r[g][CH_OFFS0 + 4'd1]) : 32'h0000_0000;
            assign serr = sraw - sr_r;
            always_comb begin
                sr_nxt = sr_r;
                if (ms_tick) begin
                    if (serr > $signed(chw_r[g][CH_SRAMP0])) begin
                        sr_nxt = sr_r + $signed(chw_r[g][CH_SRAMP0]);
                    end else if (-serr > $signed(chw_r[g][CH_SRAMP0 + 4'd1])) begin
                        sr_nxt = sr_r - $signed(chw_r[g][CH_SRAMP0 + 4'd1]);
                    end else begin
                        sr_nxt = sraw;
                    end
                end
            end
            always_ff @(posedge CLOCK or posedge RST) begin
                if (RST) begin
                    sr_r <= 32'h0000_0000;
                end else begin
                    sr_r <= sr_nxt;
                end
            end
            assign spd_ref[g] = sr_r;
        end
    endgenerate

    assign POS_REF_FIRST    = pos_ref[0];
    assign POS_REF_SECOND   = pos_ref[1];
    assign SPEED_REF_FIRST  = spd_ref[0];
    assign SPEED_REF_SECOND = spd_ref[1];

    ////////////////////////////////////////////////////////////////////////
    // Register writes
    always_comb begin
        ctrl_nxt      = ctrl_r;
        fb_nxt        = fb_r;
        func_nxt      = func_r;
        filt_nxt      = filt_r;
        chw_nxt       = chw_r;
        load_nxt      = 1'b0;                  // Load is a one-cycle request
        fb_exec_d_nxt = fb_exec;
        if (wr_en && (PADDR[31:8] == 24'h000000)) begin
            case (a8)
                REG_CTRL: begin
                    ctrl_nxt = PWDATA & ~(32'h1 << CTRL_LOAD_BIT);
                    load_nxt = PWDATA[CTRL_LOAD_BIT];
                end
                REG_FIELDBUS: fb_nxt   = {27'h0, PWDATA[4:0]};
                REG_ANA_FUNC: func_nxt = PWDATA[15:0];
                REG_FILT: begin
                    // Clamp to the top of the filter range
                    filt_nxt[6:0]  = (PWDATA[6:0]  > 7'(FILT_MAX_MS)) ? 7'(FILT_MAX_MS) : PWDATA[6:0];
                    filt_nxt[13:7] = (PWDATA[14:8] > 7'(FILT_MAX_MS)) ? 7'(FILT_MAX_MS) : PWDATA[14:8];
                end
                default: begin
                    // Word 15 is past the end of the array, so it is never written
                    if (ch_hit && ch_word != CH_SAMPLE && ch_word != CH_NWORDS) begin
                        chw_nxt[ch_sel][ch_word] = PWDATA;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            ctrl_r      <= CTRL_RESET;
            fb_r        <= 32'h0000_0000;
            func_r      <= 16'h0000;
            filt_r      <= 14'h0000;
            chw_r       <= '{default: '{default: 32'h0000_0000}};
            load_r      <= 1'b0;
            fb_exec_d_r <= 1'b0;
        end else begin
            ctrl_r      <= ctrl_nxt;
            fb_r        <= fb_nxt;
            func_r      <= func_nxt;
            filt_r      <= filt_nxt;
            chw_r       <= chw_nxt;
            load_r      <= load_nxt;
            fb_exec_d_r <= fb_exec_d_nxt;
        end
    end

    // Read mux and error for unmapped addresses
    always_comb begin
        rdata = 32'h0000_0000;
        bad   = 1'b0;
        if (PADDR[31:8] != 24'h000000 || PADDR[1:0] != 2'b00) begin
            bad = 1'b1;
        end else begin
            case (a8)
                REG_CTRL:     rdata = ctrl_r;
                REG_STATUS:   rdata = {26'h0, st_r, idx_r};
                REG_FIELDBUS: rdata = fb_r;
                REG_ANA_FUNC: rdata = {16'h0, func_r};
                REG_FILT:     rdata = {17'h0, filt_r[13:7], 1'b0, filt_r[6:0]};
                REG_POS_REF:  rdata = pos_tgt[0];
                default: begin
                    if (!ch_hit || ch_word == CH_NWORDS) begin
                        bad = 1'b1;
                    end else if (ch_word == CH_SAMPLE) begin
                        rdata = 32'(ana[ch_sel]);
                    end else begin
                        rdata = chw_r[ch_sel][ch_word];
                    end
                end
            endcase
        end
    end

    assign PRDATA  = (PSEL && PENABLE && !PWRITE) ? rdata : 32'h0000_0000;
    assign PSLVERR = PSEL && PENABLE && bad;
endmodule // drs_top

// ---- test/drs_top_chk.sv ----
// Port checker of the reference select block
`timescale 1ns/1ps
module drs_top_chk
    import drs_pkg::*;
(
    input wire logic               CLOCK,
    input wire logic               RST,
    input wire logic               PSEL,
    input wire logic               PENABLE,
    input wire logic               PREADY,
    input wire logic [31:0]        PRDATA,
    input wire logic               PSLVERR,
    input wire drs_job_s           JOB,
    input wire logic [3:0]         ACTUAL_SET_INDEX,
    input wire logic signed [31:0] POS_REF_FIRST
);
default clocking @(posedge CLOCK); endclocking
default disable iff (RST);
a_abort_with_start: assert property (JOB.start |-> JOB.abort && JOB.seq_abort) else $error("no abort");
a_start_single: assert property (JOB.start |=> !JOB.start) else $error("start too long");
a_index_kept: assert property (JOB.start |-> ##2 ACTUAL_SET_INDEX == $past(JOB.index, 2))
    else $error("index lost");
a_from_pos_job: assert property (JOB.from_pos |-> JOB.start) else $error("stray from_pos");
a_pos_ms_step: assert property ($changed(POS_REF_FIRST) |=> $stable(POS_REF_FIRST) [*8])
    else $error("reference steps too fast");
a_ready_fixed: assert property (PSEL && PENABLE |-> PREADY) else $error("slave stalled");
a_err_access: assert property (PSLVERR |-> PSEL && PENABLE) else $error("stray error");
a_rdata_quiet: assert property (!(PSEL && PENABLE) |-> PRDATA == '0) else $error("read data idle");
a_reset_clear: assert property ($fell(RST) |-> JOB == '0 && ACTUAL_SET_INDEX == '0)
    else $error("outputs after reset");
endmodule // drs_top_chk
bind drs_top drs_top_chk i_drs_top_chk (.CLOCK(CLOCK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR), .JOB(JOB), .ACTUAL_SET_INDEX(ACTUAL_SET_INDEX),
    .POS_REF_FIRST(POS_REF_FIRST));

// ---- test/drs_ctl_model.sv ----
// Model of the external controller at the select and analog pins
`timescale 1ns/1ps
module drs_ctl_model (
    input  wire logic          clk,
    output logic [3:0]         sel,
    output logic               en,
    output logic [6:0]         din,
    output logic signed [15:0] ana,
    output logic signed [15:0] ana2
);
initial begin
    sel = '0;
    en = 1'b0;
    din = 7'h01;
    ana = 16'sh4000;
    ana2 = -16'sh4000;
end
// Index settles before the enable rises, since both pass synchronisers
task automatic pick(input logic [3:0] idx);
    @(posedge clk);
    sel <= idx;
    repeat (3) @(posedge clk);
    en <= 1'b1;
endtask
// Released select lines do not keep their last value
task automatic drop();
    en <= 1'b0;
    sel <= ~sel;
endtask
endmodule // drs_ctl_model

// ---- test/drs_top_tb.sv ----
// Self-checking bench of the reference select block
`timescale 1ns/1ps
module drs_top_tb
    import drs_pkg::*;
;
logic               CLOCK = 1'b0, RST = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, en, e;
logic [31:0]        paddr = '0, pwdata = '0, prdata, rd;
logic [3:0]         sel, act_idx;
logic [6:0]         din;
logic signed [15:0] ana, ana2;
drs_job_s           job;
int                 fail_count = 0, n_checks = 0;
drs_ctl_model i_drs_ctl_model (.clk(CLOCK), .sel(sel), .en(en), .din(din), .ana(ana), .ana2(ana2));
drs_top i_drs_top (.CLOCK(CLOCK), .RST(RST), .PADDR(paddr), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr), .SET_SELECT_BITS(sel),
    .TABLE_JOB_ENABLE(en), .DIGITAL_IN(din), .ANALOG_IN_FIRST(ana), .ANALOG_IN_SECOND(ana2), .JOB(job),
    .ACTUAL_SET_INDEX(act_idx), .POS_REF_FIRST(), .POS_REF_SECOND(), .SPEED_REF_FIRST(), .SPEED_REF_SECOND());
initial forever #4 CLOCK = ~CLOCK;
task automatic finish_test(input logic hang);
    if (hang) fail_count++;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
endtask
task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
        fail_count++;
        $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
endtask
// One APB transfer; the request stands until pready is sampled high
task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge CLOCK);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
        @(posedge CLOCK);
        if (pready === 1'b1) break;
    end
    rd = prdata;
    e = pslverr;
    if (n == 20) finish_test(1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge CLOCK);
endtask
task automatic wait_job(input logic [3:0] idx, input logic fp);
    int n;
    for (n = 0; n < 20 && job.start !== 1'b1; n++) @(posedge CLOCK);
    if (n == 20) finish_test(1'b1);
    check("job index", job.index, idx);
    check("job aborts", {job.abort, job.seq_abort}, 2'b11);
    check("from position", job.from_pos, fp);
    repeat (3) @(posedge CLOCK);
    check("actual index", act_idx, idx);
endtask
task automatic t_regs();
    apb(1'b0, 32'(REG_CTRL), '0);
    check("ctrl reset", rd, CTRL_RESET);
    apb(1'b1, 32'h48, 32'h0000_7fff);
    apb(1'b0, 32'h48, '0);
    check("position scale", rd[15:0], 16'h7fff);
    apb(1'b0, 32'h7c, '0);
    check("unmapped error", e, 1'b1);
    $display("test regs done");
endtask
task automatic t_pins();
    logic [3:0] idx;
    for (int i = 0; i < 5; i++) begin
        idx = (i == 4) ? 4'hf : 4'h1 << i;
        i_drs_ctl_model.pick(idx);
        wait_job(idx, 1'b0);
        i_drs_ctl_model.drop();
    end
    $display("test pins done");
endtask
task automatic t_para();
    apb(1'b1, 32'(REG_CTRL), 32'h1c00_2190);
    wait_job(4'h9, 1'b1);
    apb(1'b1, 32'(REG_CTRL), 32'h1c00_0100);
    wait_job(4'h0, 1'b0);
    $display("test parameter jobs done");
endtask
task automatic t_bus();
    apb(1'b1, 32'(REG_CTRL), 32'h1c00_0003);
    apb(1'b1, 32'(REG_FIELDBUS), 32'h0000_000a);
    apb(1'b1, 32'(REG_FIELDBUS), 32'h0000_001a);
    wait_job(4'ha, 1'b0);
    $display("test fieldbus done");
endtask
// Channel 0 position target: scale 0x7fff from t_regs, sample 0x4000, input 0 high
task automatic t_ana();
    apb(1'b1, 32'h54, 32'h0000_0100);
    apb(1'b1, 32'(REG_ANA_FUNC), 32'h0000_00fe);
    apb(1'b0, 32'(REG_POS_REF), '0);
    check("position target", rd, 32'h0000_40ff);
    apb(1'b1, 32'h60, 32'h0000_1000);
    apb(1'b1, 32'h54, 32'h0000_0200);
    apb(1'b0, 32'(REG_POS_REF), '0);
    check("inside band", rd, 32'h0000_40ff);
    apb(1'b1, 32'(REG_CTRL), 32'h0000_0003);
    apb(1'b1, 32'h60, '0);
    apb(1'b0, 32'(REG_POS_REF), '0);
    check("gate false", rd, 32'h0000_40ff);
    apb(1'b1, 32'(REG_CTRL), 32'h1c00_0003);
    apb(1'b0, 32'(REG_POS_REF), '0);
    check("gate true", rd, 32'h0000_41ff);
    $display("test analog done");
endtask
initial begin
    repeat (12) @(posedge CLOCK);
    RST <= 1'b0;
    @(posedge CLOCK);
    t_regs();
    t_pins();
    t_para();
    t_bus();
    t_ana();
    finish_test(1'b0);
end
endmodule // drs_top_tb
